//--- core/bl_cfg.svh
// Register map, field positions, reset values and timing for the byte link host block.
// Assumes inclusion by bare name from the bl_prio and bl_host design files of the block.
`ifndef BL_CFG_SVH
`define BL_CFG_SVH

`define BL_ADDR_W        3
`define BL_OFF_SVEC      3'h0
`define BL_OFF_DATA      3'h1
`define BL_OFF_DELAY     3'h2
`define BL_OFF_PCTL      3'h3
`define BL_OFF_PDATA     3'h4
`define BL_OFF_DIR       3'h5
`define BL_OFF_CTL2      3'h6
`define BL_OFF_STAT      3'h7

`define BL_NPIN          7
`define BL_RST_BYTE      8'h00
`define BL_RST_PINS      7'h00
`define BL_RST_DELAY     8'h00

// Link control two fields
`define BL_C2_TX_END_OF_DATA_CMD       0
`define BL_C2_DIGITAL_LOOPBACK      1
`define BL_C2_ANALOG_LOOPBACK      2
// Delay config fields
`define BL_DLY_ATE       7
`define BL_DLY_RX_PIN_POLARITY     6
`define BL_DLY_OFF_HI    3
// Port control fields
`define BL_PC_EN         2
`define BL_PC_PUP        1
`define BL_PC_RDR        0
// Link pins: 0 receive, 1 transmit
`define BL_PIN_RX        0
`define BL_PIN_TX        1

// Source numbers (vector = code * 4)
`define BL_SRC_NONE      4'h0
`define BL_SRC_EOF       4'h1
`define BL_SRC_RX_RESPONSE_BYTE     4'h2
`define BL_SRC_RX_BYTE_FULL      4'h3
`define BL_SRC_TX_BYTE_EMPTY      4'h4
`define BL_SRC_LOA       4'h5
`define BL_SRC_CRC       4'h6
`define BL_SRC_INV       4'h7
`define BL_SRC_WAKE      4'h8
`define BL_NSRC          9

// Timing: bit time of the simplified serialiser, base delay figures
`define BL_CLK_MHZ       20
`define BL_BIT_US        64
`define BL_BIT_CYC       (`BL_BIT_US * `BL_CLK_MHZ)
`define BL_DLY_BASE_US   9
`define BL_DLY_STEP_US   1
`define BL_EXTRA_ONES    2
`define BL_BITS          8

`endif

//--- core/bl_pkg.sv
// Types shared by the byte link host block.
// Assumes bl_cfg.svh for numeric constants.
package bl_pkg;
  typedef logic [7:0] bl_byte_t;
  typedef logic [3:0] bl_src_t;
  typedef enum logic [1:0] {BL_TX_IDLE, BL_TX_SHIFT, BL_TX_ONES, BL_TX_EOD} bl_tx_t;
endpackage

//--- core/bl_prio.sv
// Priority encoder picking the highest pending source number.
// Assumes pending bit n means source n; bit 0 unused.
`timescale 1ns/1ps
`include "bl_cfg.svh"
module bl_prio
  import bl_pkg::*;
(
  input  wire logic [`BL_NSRC-1:0] i_pend,
  output bl_pkg::bl_src_t          o_src
);
  always_comb
  begin
    o_src = `BL_SRC_NONE;
    for (int n = 1; n < `BL_NSRC; n++)
    begin
      if (i_pend[n])
      begin
        o_src = 4'(n);
      end
    end
  end
endmodule

//--- core/bl_host.sv
// Byte link controller register block: state vector, data buffers, delay config, port.
// Assumes a single-cycle register port and an external J1850 transceiver on pins.
`timescale 1ns/1ps
`include "bl_cfg.svh"
// Contract
// - State vector shows a 4-bit source code in bits 5..2.
// - Highest pending source shown; next one appears when it clears.
// - Vector read clears source, except rx full, response byte, tx empty.
// - Rx full and response byte clear after vector read then data read.
// - Tx empty clears after vector read then data write, or end-of-data command.
// - After invalid symbol clears, no rx or tx until end-of-frame seen.
// - Either loopback bit detaches the link; no bus data raises sources.
// - Data read returns last received byte; write hands byte to transmitter.
// - Shadow moves into shifter; tx empty rises after first bit shifted.
// - Full received byte goes to shadow, raising rx full (response byte if IFR); overwritten later.
// - Missing byte causes underrun; byte plus two ones, then transmitter off.
// - Aborted transmission reported as invalid symbol source.
// - Transceiver select 0 off-chip, 1 on-board; keep cleared.
// - Receive polarity 0 inverts receive pin, 1 passes it true.
// - Delay offset maps 0000 to 9 us, one us per step, 24 max.
// - Delay register readable always; one write normal, unlimited special.
// - Link enable 1 gives pins to link; 0 makes pins general I/O.
// - Pullup bit connects pullups; reduced-drive bit lowers drive strength.
// - Port data read returns pin level for inputs, latch for outputs.
// - Port writes leave link-driven pins alone; reset leaves all pins inputs.
// - End-of-data command sends end-of-data after the current byte.
// - Direction bit 1 makes pin output, 0 input.
module bl_host
  import bl_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_arst_n,
  input  wire logic                    i_special,
  input  wire logic [`BL_ADDR_W-1:0]   i_addr,
  input  wire logic [7:0]              i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output bl_pkg::bl_byte_t             o_rdata,
  input  wire logic                    i_rx_byte,
  input  wire logic [7:0]              i_rx_data,
  input  wire logic                    i_rx_ifr,
  input  wire logic                    i_rx_eof,
  input  wire logic                    i_loa,
  input  wire logic                    i_crc_err,
  input  wire logic                    i_sym_err,
  input  wire logic                    i_wake,
  input  wire logic [`BL_NPIN-1:0]     i_pin,
  output logic      [`BL_NPIN-1:0]     o_pin,
  output logic      [`BL_NPIN-1:0]     o_pin_oe,
  output logic                         o_pullup,
  output logic                         o_reduced_drive,
  output logic                         o_link_active,
  output logic [3:0]                   o_delay_offset,
  output logic                         o_irq
);
  import bl_pkg::*;

  // Registers
  logic [7:0]              ctl2;
  logic [7:0]              delay_cfg;
  logic                    delay_locked;
  logic [2:0]              pctl;
  logic [`BL_NPIN-1:0]     pdata;
  logic [`BL_NPIN-1:0]     pdir;
  logic [`BL_NPIN-1:0]     pin_s1;
  logic [`BL_NPIN-1:0]     pin_s2;
  logic [`BL_NPIN-1:0]     pin_s3;
  logic [`BL_NPIN-1:0]     pin_lvl;
  bl_byte_t                rx_shadow;
  bl_byte_t                tx_shadow;
  logic                    tx_shadow_full;
  bl_byte_t                tx_shift;
  logic [3:0]              tx_bit;
  logic [15:0]             bit_cnt;
  bl_tx_t                  tx_state;
  logic                    eod_pend;
  logic                    inv_lock;
  logic [`BL_NSRC-1:0]     pend;
  logic                    svec_read;
  bl_src_t                 cur_src;
  bl_src_t                 next_src;
  logic                    link_on;
  logic                    link_rx;
  logic                    underrun;
  logic                    first_bit;
  logic                    tx_start;
  logic                    bit_tick;
  logic                    rx_pin_true;

  wire wr_data  = i_wr && (i_addr == `BL_OFF_DATA);
  wire rd_data  = i_rd && (i_addr == `BL_OFF_DATA);
  wire rd_svec  = i_rd && (i_addr == `BL_OFF_SVEC);
  wire wr_ctl2  = i_wr && (i_addr == `BL_OFF_CTL2);
  wire tx_end_of_data_cmd_set = wr_ctl2 && i_wdata[`BL_C2_TX_END_OF_DATA_CMD];

  bl_prio bl_prio_inst
  (
    .i_pend (pend),
    .o_src  (next_src)
  );

  // Link runs only when enabled, not in loopback, not waiting after invalid symbol
  assign link_rx = pctl[`BL_PC_EN]
                && !ctl2[`BL_C2_DIGITAL_LOOPBACK] && !ctl2[`BL_C2_ANALOG_LOOPBACK];
  assign link_on = link_rx && !inv_lock;

  // Pin synchroniser: change accepted once stages two and three agree
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_s1  <= `BL_RST_PINS;
      pin_s2  <= `BL_RST_PINS;
      pin_s3  <= `BL_RST_PINS;
      pin_lvl <= `BL_RST_PINS;
    end
    else
    begin
      pin_s1 <= i_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int n = 0; n < `BL_NPIN; n++)
      begin
        if (pin_s2[n] == pin_s3[n])
        begin
          pin_lvl[n] <= pin_s3[n];
        end
      end
    end
  end

  // Receive pin level seen by the codec, polarity corrected
  assign rx_pin_true = delay_cfg[`BL_DLY_RX_PIN_POLARITY] ? pin_lvl[`BL_PIN_RX]
                                                 : !pin_lvl[`BL_PIN_RX];

  // Control registers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctl2         <= `BL_RST_BYTE;
      delay_cfg    <= `BL_RST_DELAY;
      delay_locked <= 1'b0;
      pctl         <= 3'h0;
      pdir         <= `BL_RST_PINS;
      pdata        <= `BL_RST_PINS;
    end
    else
    begin
      if (wr_ctl2)
      begin
        ctl2 <= i_wdata & 8'hFE;
      end
      if (i_wr && i_addr == `BL_OFF_DELAY && (!delay_locked || i_special))
      begin
        delay_cfg    <= i_wdata;
        delay_locked <= 1'b1;
      end
      if (i_wr && i_addr == `BL_OFF_PCTL)
      begin
        pctl <= i_wdata[2:0];
      end
      if (i_wr && i_addr == `BL_OFF_DIR)
      begin
        pdir <= i_wdata[`BL_NPIN-1:0];
      end
      if (i_wr && i_addr == `BL_OFF_PDATA)
      begin
        pdata <= i_wdata[`BL_NPIN-1:0];
      end
    end
  end

  // Transmit bit timer
  assign bit_tick = (bit_cnt == 16'(`BL_BIT_CYC - 1));
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bit_cnt <= 16'h0000;
    end
    else if (tx_state == BL_TX_IDLE || bit_tick)
    begin
      bit_cnt <= 16'h0000;
    end
    else
    begin
      bit_cnt <= bit_cnt + 16'h0001;
    end
  end

  assign tx_start  = (tx_state == BL_TX_IDLE) && tx_shadow_full && link_on;
  assign first_bit = (tx_state == BL_TX_SHIFT) && bit_tick && (tx_bit == 4'h0);
  assign underrun  = (tx_state == BL_TX_SHIFT) && bit_tick
                  && (tx_bit == 4'(`BL_BITS - 1)) && !tx_shadow_full && !eod_pend;

  // Transmit shadow
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tx_shadow      <= `BL_RST_BYTE;
      tx_shadow_full <= 1'b0;
      eod_pend       <= 1'b0;
    end
    else
    begin
      if (wr_data)
      begin
        tx_shadow      <= i_wdata;
        tx_shadow_full <= 1'b1;
      end
      else if (tx_start || ((tx_state == BL_TX_SHIFT) && bit_tick
               && tx_bit == 4'(`BL_BITS - 1)))
      begin
        tx_shadow_full <= 1'b0;
      end
      if (tx_end_of_data_cmd_set)
      begin
        eod_pend <= 1'b1;
      end
      else if (tx_state == BL_TX_EOD)
      begin
        eod_pend <= 1'b0;
      end
    end
  end

  // Transmit serialiser
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tx_state <= BL_TX_IDLE;
      tx_shift <= `BL_RST_BYTE;
      tx_bit   <= 4'h0;
    end
    else if (!link_on && tx_state != BL_TX_ONES)
    begin
      tx_state <= BL_TX_IDLE;
    end
    else
    begin
      case (tx_state)
        BL_TX_IDLE:
        begin
          if (tx_start)
          begin
            tx_shift <= tx_shadow;
            tx_bit   <= 4'h0;
            tx_state <= BL_TX_SHIFT;
          end
        end
        BL_TX_SHIFT:
        begin
          if (bit_tick)
          begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            tx_bit   <= tx_bit + 4'h1;
            if (tx_bit == 4'(`BL_BITS - 1))
            begin
              tx_bit <= 4'h0;
              if (tx_shadow_full)
              begin
                tx_shift <= tx_shadow;
              end
              else if (eod_pend)
              begin
                tx_state <= BL_TX_EOD;
              end
              else
              begin
                tx_state <= BL_TX_ONES;
              end
            end
          end
        end
        BL_TX_ONES:
        begin
          if (bit_tick)
          begin
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == 4'(`BL_EXTRA_ONES - 1))
            begin
              tx_state <= BL_TX_IDLE;
            end
          end
        end
        BL_TX_EOD:
        begin
          if (bit_tick)
          begin
            tx_state <= BL_TX_IDLE;
          end
        end
        default:
        begin
          tx_state <= BL_TX_IDLE;
        end
      endcase
    end
  end

  // Receive shadow, latest byte wins
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rx_shadow <= `BL_RST_BYTE;
    end
    else if (i_rx_byte && link_on)
    begin
      rx_shadow <= i_rx_data;
    end
  end

  // Pending sources; set wins over clear
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pend      <= '0;
      svec_read <= 1'b0;
      cur_src   <= `BL_SRC_NONE;
      inv_lock  <= 1'b0;
    end
    else
    begin
      if (rd_svec)
      begin
        cur_src   <= next_src;
        svec_read <= 1'b1;
        if (next_src != `BL_SRC_RX_BYTE_FULL && next_src != `BL_SRC_RX_RESPONSE_BYTE
            && next_src != `BL_SRC_TX_BYTE_EMPTY)
        begin
          pend[next_src] <= 1'b0;
          if (next_src == `BL_SRC_INV)
          begin
            inv_lock <= 1'b1;
          end
        end
      end
      if (svec_read && rd_data
          && (cur_src == `BL_SRC_RX_BYTE_FULL || cur_src == `BL_SRC_RX_RESPONSE_BYTE))
      begin
        pend[cur_src] <= 1'b0;
        svec_read     <= 1'b0;
      end
      if ((svec_read && wr_data && cur_src == `BL_SRC_TX_BYTE_EMPTY) || tx_end_of_data_cmd_set)
      begin
        pend[`BL_SRC_TX_BYTE_EMPTY] <= 1'b0;
        svec_read          <= 1'b0;
      end
      // End of frame still heard while locked; it is what releases the lock
      if (i_rx_eof && link_rx)
      begin
        inv_lock          <= 1'b0;
        pend[`BL_SRC_EOF] <= 1'b1;
      end
      if (link_on)
      begin
        if (i_rx_byte && i_rx_ifr)  pend[`BL_SRC_RX_RESPONSE_BYTE] <= 1'b1;
        if (i_rx_byte && !i_rx_ifr) pend[`BL_SRC_RX_BYTE_FULL]  <= 1'b1;
        if (i_loa)     pend[`BL_SRC_LOA]   <= 1'b1;
        if (i_crc_err) pend[`BL_SRC_CRC]   <= 1'b1;
        if (i_sym_err) pend[`BL_SRC_INV]   <= 1'b1;
        if (i_wake)    pend[`BL_SRC_WAKE]  <= 1'b1;
      end
      if (first_bit)
      begin
        pend[`BL_SRC_TX_BYTE_EMPTY] <= 1'b1;
      end
      if (underrun)
      begin
        pend[`BL_SRC_INV] <= 1'b1;
      end
    end
  end

  // Pins, read data and interrupt request
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pin           <= `BL_RST_PINS;
      o_pin_oe        <= `BL_RST_PINS;
      o_pullup        <= 1'b0;
      o_reduced_drive <= 1'b0;
      o_link_active   <= 1'b0;
      o_delay_offset  <= 4'h0;
      o_irq           <= 1'b0;
      o_rdata         <= `BL_RST_BYTE;
    end
    else
    begin
      o_pin    <= pdata;
      o_pin_oe <= pdir;
      if (pctl[`BL_PC_EN])
      begin
        o_pin_oe[`BL_PIN_RX] <= 1'b0;
        o_pin_oe[`BL_PIN_TX] <= 1'b1;
        o_pin[`BL_PIN_TX]    <= (tx_state == BL_TX_SHIFT) ? tx_shift[7]
                              : (tx_state == BL_TX_ONES);
      end
      o_pullup        <= pctl[`BL_PC_PUP];
      o_reduced_drive <= pctl[`BL_PC_RDR];
      o_link_active   <= link_on;
      o_delay_offset  <= delay_cfg[`BL_DLY_OFF_HI:0];
      o_irq           <= (next_src != `BL_SRC_NONE);
      case (i_addr)
        `BL_OFF_SVEC:  o_rdata <= {2'b00, next_src, 2'b00};
        `BL_OFF_DATA:  o_rdata <= rx_shadow;
        `BL_OFF_DELAY: o_rdata <= delay_cfg;
        `BL_OFF_PCTL:  o_rdata <= {5'h00, pctl};
        `BL_OFF_PDATA: o_rdata <= {1'b0, (pdir & pdata) | (~pdir & pin_lvl)};
        `BL_OFF_DIR:   o_rdata <= {1'b0, pdir};
        `BL_OFF_CTL2:  o_rdata <= ctl2;
        `BL_OFF_STAT:  o_rdata <= {5'h00, rx_pin_true, inv_lock, tx_shadow_full};
        default:       o_rdata <= `BL_RST_BYTE;
      endcase
    end
  end

  // Checks
  sequence tx_byte_done_s;
    (tx_state == BL_TX_SHIFT) && bit_tick && tx_bit == 4'(`BL_BITS - 1);
  endsequence

  sequence no_reload_s;
    !tx_shadow_full && !eod_pend;
  endsequence

  svec_code_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rd && i_addr == `BL_OFF_SVEC |=> o_rdata[1:0] == 2'b00 && o_rdata[7:6] == 2'b00
      && o_rdata[5:2] == $past(next_src)) else $error("vector code wrong");
  svec_prio_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    pend[`BL_SRC_WAKE] |-> next_src == `BL_SRC_WAKE) else $error("wakeup not top");
  svec_clear_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    rd_svec && next_src == `BL_SRC_EOF && !i_rx_eof |=> !pend[`BL_SRC_EOF])
    else $error("source not cleared");
  rx_byte_full_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    rd_svec && next_src == `BL_SRC_RX_BYTE_FULL |=> pend[`BL_SRC_RX_BYTE_FULL])
    else $error("rx full cleared early");
  tx_byte_empty_tx_end_of_data_cmd_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    tx_end_of_data_cmd_set && !first_bit |=> !pend[`BL_SRC_TX_BYTE_EMPTY]) else $error("tx empty kept");
  loop_detach_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ctl2[`BL_C2_DIGITAL_LOOPBACK] || ctl2[`BL_C2_ANALOG_LOOPBACK]) |=> !o_link_active && $stable(rx_shadow))
    else $error("loop attached");
  tx_byte_empty_first_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    first_bit |=> pend[`BL_SRC_TX_BYTE_EMPTY]) else $error("tx empty late");
  underrun_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    tx_byte_done_s ##0 no_reload_s ##0 !wr_data && link_on
      |=> tx_state == BL_TX_ONES && pend[`BL_SRC_INV]) else $error("no underrun");
  irq_level_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_irq == ($past(next_src) != `BL_SRC_NONE)) else $error("irq mismatch");
endmodule

//--- testbench/bl_xcvr_model.sv
// Far-side model: external transceiver on the link pins plus codec event pulses.
// Assumes the bench calls its tasks; pin levels resolve from the device enables.
`timescale 1ns/1ps
module bl_xcvr_model
(
  input  wire logic       i_clk,
  input  wire logic [6:0] i_pin_out,
  input  wire logic [6:0] i_pin_oe,
  input  wire logic [6:0] i_ext,
  output logic      [6:0] o_pin,
  output logic            o_rx_byte,
  output logic      [7:0] o_rx_data,
  output logic            o_rx_ifr,
  output logic      [4:0] o_evt
);
  initial
  begin
    o_rx_byte = 1'b0;
    o_rx_data = 8'h00;
    o_rx_ifr  = 1'b0;
    o_evt     = 5'h00;
  end

  // Inverting transceiver echoes the transmit pin onto receive
  always_comb
  begin
    for (int i = 0; i < 7; i++)
      o_pin[i] = i_pin_oe[i] ? i_pin_out[i] : i_ext[i];
    if (!i_pin_oe[0] && i_pin_oe[1])
      o_pin[0] = ~i_pin_out[1];
  end

  task automatic rx_byte(input logic [7:0] d, input logic ifr);
    @(posedge i_clk);
    o_rx_byte <= 1'b1;
    o_rx_data <= d;
    o_rx_ifr  <= ifr;
    @(posedge i_clk);
    o_rx_byte <= 1'b0;
    o_rx_data <= ~d;
    o_rx_ifr  <= ~ifr;
  endtask

  // Bits: 0 end of frame, 1 lost arbitration, 2 crc, 3 bad symbol, 4 wakeup
  task automatic pulse(input logic [4:0] m);
    @(posedge i_clk);
    o_evt <= m;
    @(posedge i_clk);
    o_evt <= 5'h00;
  endtask
endmodule

//--- testbench/bl_host_tb_top.sv
// Self-checking bench for the byte link host register block.
// Assumes the transceiver model on the far side and the register map header.
`timescale 1ns/1ps
`include "bl_cfg.svh"
module bl_host_tb_top;
  import bl_pkg::*;
  logic       clk, arst_n, special, wr, rd, rxb, ifr, pup, rdr, act, irq;
  logic [2:0] addr;
  logic [7:0] wdata, rxd;
  bl_byte_t   rdata;
  logic [3:0] dly;
  logic [4:0] evt;
  logic [6:0] pin, pout, poe, ext;
  int         num_errors, checks_done;

  bl_host bl_host_inst (.i_clk(clk), .i_arst_n(arst_n), .i_special(special),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_rx_byte(rxb), .i_rx_data(rxd), .i_rx_ifr(ifr), .i_rx_eof(evt[0]),
    .i_loa(evt[1]), .i_crc_err(evt[2]), .i_sym_err(evt[3]), .i_wake(evt[4]),
    .i_pin(pin), .o_pin(pout), .o_pin_oe(poe), .o_pullup(pup),
    .o_reduced_drive(rdr), .o_link_active(act), .o_delay_offset(dly), .o_irq(irq));
  bl_xcvr_model bl_xcvr_model_inst (.i_clk(clk), .i_pin_out(pout), .i_pin_oe(poe),
    .i_ext(ext), .o_pin(pin), .o_rx_byte(rxb), .o_rx_data(rxd), .o_rx_ifr(ifr),
    .o_evt(evt));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    check(what, exp, d);
  endtask

  // Poll the vector with a bounded number of reads
  task automatic wait_vec(input logic [7:0] exp);
    logic [7:0] d;
    for (int n = 0; n < 100; n++)
    begin
      rd_reg(`BL_OFF_SVEC, d);
      if (d === exp)
        return;
      repeat (200) @(posedge clk);
    end
    check("vector wait", exp, d);
    end_sim();
  endtask

  initial
  begin
    num_errors  = 0;
    checks_done = 0;
    arst_n = 1'b0;
    special = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    ext = 7'h00;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 7; a++)
      rd_chk("reset value", a[2:0], 8'h00);
    check("pins after reset", 8'h00, {1'b0, poe});
    check("irq after reset", 8'h00, {7'h00, irq});
    // Delay register: one write only unless special mode
    wr_reg(`BL_OFF_DELAY, 8'h4F);
    rd_chk("delay", `BL_OFF_DELAY, 8'h4F);
    check("offset", 8'h0F, {4'h0, dly});
    wr_reg(`BL_OFF_DELAY, 8'h00);
    rd_chk("delay locked", `BL_OFF_DELAY, 8'h4F);
    special <= 1'b1;
    wr_reg(`BL_OFF_DELAY, 8'h43);
    rd_chk("delay special", `BL_OFF_DELAY, 8'h43);
    special <= 1'b0;
    // General-purpose port
    ext <= 7'h2A;
    wr_reg(`BL_OFF_PCTL, 8'h03);
    wr_reg(`BL_OFF_DIR, 8'h0F);
    wr_reg(`BL_OFF_PDATA, 8'h55);
    repeat (5) @(posedge clk);
    check("pullup drive", 8'h03, {6'h00, pup, rdr});
    check("link off", 8'h00, {7'h00, act});
    check("oe", 8'h0F, {1'b0, poe});
    check("pin out", 8'h05, {4'h0, pout[3:0]});
    rd_chk("port data", `BL_OFF_PDATA, 8'h25);
    wr_reg(`BL_OFF_DIR, 8'h00);
    wr_reg(`BL_OFF_PCTL, 8'h04);
    repeat (2) @(posedge clk);
    check("link on", 8'h01, {7'h00, act});
    check("link oe", 8'h02, {1'b0, poe});
    wr_reg(`BL_OFF_PDATA, 8'h7F);
    repeat (2) @(posedge clk);
    check("link pin", 8'h00, {7'h00, pout[1]});
    // Priority and read-to-clear
    bl_xcvr_model_inst.pulse(5'h11);
    repeat (2) @(posedge clk);
    check("irq", 8'h01, {7'h00, irq});
    rd_chk("vec wake", `BL_OFF_SVEC, 8'h20);
    rd_chk("vec eof", `BL_OFF_SVEC, 8'h04);
    rd_chk("vec none", `BL_OFF_SVEC, 8'h00);
    for (int k = 1; k < 3; k++)
    begin
      bl_xcvr_model_inst.pulse(5'h01 << k);
      rd_chk("vec err", `BL_OFF_SVEC, 8'h10 + 8'(k * 4));
    end
    rd_chk("vec clear", `BL_OFF_SVEC, 8'h00);
    rd_chk("rx true", `BL_OFF_STAT, 8'h04);
    special <= 1'b1;
    wr_reg(`BL_OFF_DELAY, 8'h03);
    special <= 1'b0;
    rd_chk("rx inverted", `BL_OFF_STAT, 8'h00);
    // Received bytes need vector read then data read
    for (int k = 0; k < 2; k++)
    begin
      bl_xcvr_model_inst.rx_byte(8'hA5 ^ 8'(k), k[0]);
      rd_chk("vec rx", `BL_OFF_SVEC, k ? 8'h08 : 8'h0C);
      rd_chk("vec rx held", `BL_OFF_SVEC, k ? 8'h08 : 8'h0C);
      rd_chk("rx data", `BL_OFF_DATA, 8'hA5 ^ 8'(k));
      rd_chk("vec rx done", `BL_OFF_SVEC, 8'h00);
    end
    // Either loopback detaches the link
    for (int k = 1; k < 3; k++)
    begin
      wr_reg(`BL_OFF_CTL2, 8'h01 << k);
      bl_xcvr_model_inst.rx_byte(8'h3C, 1'b0);
      bl_xcvr_model_inst.pulse(5'h10);
      check("loop link", 8'h00, {7'h00, act});
      rd_chk("loop vec", `BL_OFF_SVEC, 8'h00);
      rd_chk("loop data", `BL_OFF_DATA, 8'hA4);
    end
    wr_reg(`BL_OFF_CTL2, 8'h00);
    // Transmit, reload once, then underrun
    wr_reg(`BL_OFF_DATA, 8'h81);
    wait_vec(8'h10);
    wr_reg(`BL_OFF_DATA, 8'h3C);
    rd_chk("tx_byte_empty cleared", `BL_OFF_SVEC, 8'h00);
    wait_vec(8'h10);
    wait_vec(8'h1C);
    check("extra ones", 8'h01, {7'h00, pout[1]});
    repeat (2) @(posedge clk);
    check("locked", 8'h00, {7'h00, act});
    wr_reg(`BL_OFF_CTL2, 8'h01);
    rd_chk("tx_end_of_data_cmd clears", `BL_OFF_SVEC, 8'h00);
    bl_xcvr_model_inst.pulse(5'h01);
    repeat (2) @(posedge clk);
    check("unlocked", 8'h01, {7'h00, act});
    rd_chk("vec eof2", `BL_OFF_SVEC, 8'h04);
    rd_chk("vec end", `BL_OFF_SVEC, 8'h00);
    repeat (2) @(posedge clk);
    check("irq off", 8'h00, {7'h00, irq});
    end_sim();
  end
endmodule
